// [inc/sbcw_regs.svh]
`ifndef SBCW_REGS_SVH
`define SBCW_REGS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define SBCW_ADDR_WDOG 7'h03
`define SBCW_ADDR_BUS 7'h04
`define SBCW_ADDR_IWAKE 7'h06
`define SBCW_ADDR_EWAKE 7'h07

// ----------------------------------------
// Reset, restart and write masks
// ----------------------------------------
`define SBCW_WDOG_POR 8'h14
`define SBCW_WDOG_WMASK 8'hf7
`define SBCW_WDOG_KEEP 8'hb0
`define SBCW_WDOG_RESTART 8'h04
`define SBCW_BUS_POR 8'h00
`define SBCW_BUS_POR_DEV 8'h03
`define SBCW_BUS_WMASK 8'h03
`define SBCW_BUS_KEEP 8'h00
`define SBCW_BUS_FAILSAFE 8'h01
`define SBCW_IWAKE_POR 8'h00
`define SBCW_IWAKE_WMASK 8'h44
`define SBCW_IWAKE_KEEP 8'h40
`define SBCW_IWAKE_CLR_STOP 8'h04
`define SBCW_EWAKE_POR 8'h01
`define SBCW_EWAKE_WMASK 8'ha1
`define SBCW_EWAKE_KEEP 8'ha1
`define SBCW_EWAKE_FS_MASK 8'h5f
`define SBCW_EWAKE_FS_VAL 8'h01
`define SBCW_ZERO8 8'h00
`define SBCW_ALL8 8'hff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SBCW_WD_OFF_A 6
`define SBCW_WD_WINDOW 5
`define SBCW_WD_BUS_START 4
`define SBCW_IW_CYCLIC 6
`define SBCW_IW_OFF_B 2
`define SBCW_EW_GLOBAL 7
`define SBCW_EW_VSENSE 5
`define SBCW_EW_PIN 0
`define SBCW_WD_PERIOD_HI 2
`define SBCW_WD_PERIOD_LO 0
`define SBCW_BUS_MODE_HI 1
`define SBCW_BUS_MODE_LO 0

// ----------------------------------------
// Watchdog periods in ms, frame sizes
// ----------------------------------------
`define SBCW_P0_MS 14'h000a
`define SBCW_P1_MS 14'h0014
`define SBCW_P2_MS 14'h0032
`define SBCW_P3_MS 14'h0064
`define SBCW_P4_MS 14'h00c8
`define SBCW_P5_MS 14'h01f4
`define SBCW_P6_MS 14'h03e8
`define SBCW_P7_MS 14'h2710
`define SBCW_FRAME_BITS 5'h10
`define SBCW_HEAD_BITS 5'h08

`endif

// [inc/sbcw_pkg.sv]
package sbcw_pkg;

  typedef enum logic [1:0] {
    SBCW_CAN_OFF,
    SBCW_CAN_WAKE,
    SBCW_CAN_RX_ONLY,
    SBCW_CAN_NORMAL
  } sbcw_can_mode_t;

  typedef enum logic {
    SBCW_SPI_IDLE,
    SBCW_SPI_SHIFT
  } sbcw_spi_state_t;

  typedef struct packed {
    sbcw_spi_state_t state;
    logic [4:0] cnt;
    logic [15:0] rx;
    logic [7:0] tx;
    logic sclk_q;
    logic wr;
    logic done;
    logic bad_len;
  } sbcw_spi_st_t;

  typedef struct packed {
    logic [7:0] q;
  } sbcw_reg_st_t;

endpackage

// [logic/sbcw_cfg_reg.sv]
`timescale 1ns/1ps
`include "sbcw_regs.svh"

module sbcw_cfg_reg import sbcw_pkg::*; #(
  parameter logic [7:0] POR = 8'h00,
  parameter logic [7:0] WMASK = 8'hff,
  parameter logic [7:0] KEEP = 8'h00
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic soft_rst,
  input wire logic [7:0] soft_val,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic restart,
  input wire logic [7:0] restart_val,
  input wire logic force_en,
  input wire logic [7:0] force_mask,
  input wire logic [7:0] force_val,
  output logic [7:0] q
);
  sbcw_reg_st_t st;
  sbcw_reg_st_t next_st;

  // ----------------------------------------
  // Priority: soft reset, hardware force, restart, write
  // ----------------------------------------
  always_comb begin
    next_st = st;
    if (wr) begin
      next_st.q = wdata & WMASK;
    end
    if (restart) begin
      next_st.q = (st.q & KEEP) | (restart_val & ~KEEP & WMASK);
    end
    if (force_en) begin
      next_st.q = ((next_st.q & ~force_mask) | (force_val & force_mask)) & WMASK;
    end
    if (soft_rst) begin
      next_st.q = soft_val & WMASK;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st.q <= POR;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign q = st.q;
endmodule

// [logic/sbcw_spi_slave.sv]
`timescale 1ns/1ps
`include "sbcw_regs.svh"

module sbcw_spi_slave import sbcw_pkg::*; (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic [7:0] head_byte,
  input wire logic [7:0] rdata,
  output logic [6:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic done,
  output logic bad_len
);
  sbcw_spi_st_t st;
  sbcw_spi_st_t next_st;
  logic rise;
  logic fall;

  // ----------------------------------------
  // Shift engine: sample on sclk rise, shift out on fall
  // ----------------------------------------
  // Sclk is oversampled, so it must stay well under mclk/4
  assign rise = sclk & ~st.sclk_q;
  assign fall = ~sclk & st.sclk_q;

  always_comb begin
    next_st = st;
    next_st.sclk_q = sclk;
    next_st.wr = 1'b0;
    next_st.done = 1'b0;
    next_st.bad_len = 1'b0;
    unique case (st.state)
      SBCW_SPI_IDLE: begin
        if (!cs_n) begin
          next_st.state = SBCW_SPI_SHIFT;
          next_st.cnt = 5'h00;
          next_st.tx = head_byte;
        end
      end
      SBCW_SPI_SHIFT: begin
        if (cs_n) begin
          next_st.state = SBCW_SPI_IDLE;
          next_st.done = (st.cnt == `SBCW_FRAME_BITS);
          next_st.wr = (st.cnt == `SBCW_FRAME_BITS) & st.rx[0];
          next_st.bad_len = (st.cnt != `SBCW_FRAME_BITS);
        end else begin
          if (rise) begin
            next_st.rx = {mosi, st.rx[15:1]};
            if (st.cnt != `SBCW_FRAME_BITS) begin
              next_st.cnt = st.cnt + 5'h01;
            end
          end
          if (fall) begin
            // Address is complete after the head byte: old content goes out
            next_st.tx = (st.cnt == `SBCW_HEAD_BITS) ? rdata : {1'b0, st.tx[7:1]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{state: SBCW_SPI_IDLE, cnt: 5'h00, rx: 16'h0000, tx: 8'h00,
              sclk_q: 1'b0, wr: 1'b0, done: 1'b0, bad_len: 1'b0};
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Head byte arrives first: rw flag in bit 0, then address
  assign addr = (st.state == SBCW_SPI_SHIFT) ? st.rx[15:9] : st.rx[7:1];
  assign wdata = st.rx[15:8];
  assign wr = st.wr;
  assign done = st.done;
  assign bad_len = st.bad_len;
  assign miso = st.tx[0];
  assign miso_oe = ~cs_n;
endmodule

// [logic/sbcw_cfg_top.sv]
`timescale 1ns/1ps
`include "sbcw_regs.svh"

// What this block does
// - Watchdog bit 6 requests watchdog off in Stop Mode.
// - Watchdog bit 5 picks time-out (0) or window (1) operation.
// - Watchdog bit 4 set: bus wake in Stop starts long open window.
// - Period code 2:0 maps to 10,20,50,100,200,500,1000,10000 ms.
// - Watchdog control loads 0x14 on power-on or soft reset.
// - Restart keeps watchdog bits 7,5,4, clears 6, period 200, bit 3 zero.
// - Bus control 1:0 selects off, wake capable, receive only, normal.
// - Failure fail-safe entry overwrites bus control with 0x01.
// - Development mode makes transceiver reset value normal operation.
// - Restart zeroes bus bits 7:2, mode bits from cause-dependent value.
// - Internal wake bit 6 enables cyclic timer as wake source.
// - Internal wake bit 2 is the second stop-mode watchdog off bit.
// - Stop to Normal transition clears the second watchdog off bit.
// - Restart keeps timer wake enable, clears other internal wake bits.
// - External wake bit 7 lets all status bits drive the interrupt.
// - External wake bit 5 turns wake pin into voltage sense, no wakes.
// - External wake control loads 0x01 on power-on or soft reset.
// - Restart keeps external wake bits 7,5,0 and clears the rest.
// - Reserved bits ignore writes and read as zero.
// - Failure fail-safe without voltage sense forces external wake x0x0 0001.

module sbcw_cfg_top import sbcw_pkg::*; (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic soft_reset,
  input wire logic restart_entry,
  input wire logic [1:0] restart_can_mode,
  input wire logic failsafe_entry,
  input wire logic dev_mode,
  input wire logic stop_to_normal,
  input wire logic in_stop,
  input wire logic bus_wake_in_stop,
  input wire logic wake_pending,
  input wire logic status_pending,
  output logic wdog_window,
  output logic [2:0] period_select,
  output logic [13:0] wdog_period_ms,
  output logic wdog_halted,
  output logic wdog_long_window_start,
  output logic [1:0] can_mode,
  output logic cyclic_wake_enable,
  output logic pin_wake_enable,
  output logic voltage_sense_select,
  output logic cfg_write_fail,
  output logic irq_out_n
);

  // ----------------------------------------
  // Local state
  // ----------------------------------------
  typedef struct packed {
    logic boot;
    logic spi_fail;
    logic wdog_off_stop;
    logic long_start;
    logic fail_pulse;
    logic irq_n;
    logic [13:0] period_ms;
  } sbcw_top_st_t;

  sbcw_top_st_t st;
  sbcw_top_st_t next_st;

  logic [7:0] wdog_q;
  logic [7:0] bus_q;
  logic [7:0] iwake_q;
  logic [7:0] ewake_q;
  logic [6:0] spi_addr;
  logic [7:0] spi_wdata;
  logic spi_wr;
  logic spi_done;
  logic spi_bad_len;
  logic [7:0] rdata;
  logic any_soft;
  logic parity_ok;
  logic wr_wdog;
  logic wr_bus;
  logic wr_iwake;
  logic wr_ewake;
  logic ew_force;
  logic [2:0] period_code;
  logic [1:0] mode_code;
  logic [7:0] head_status;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic hit(input logic [6:0] a, input logic [6:0] target);
    hit = (a == target);
  endfunction

  function automatic logic [13:0] period_ms_of(input logic [2:0] code);
    logic [13:0] ms;
    ms = `SBCW_P0_MS;
    unique case (code)
      3'h0: ms = `SBCW_P0_MS;
      3'h1: ms = `SBCW_P1_MS;
      3'h2: ms = `SBCW_P2_MS;
      3'h3: ms = `SBCW_P3_MS;
      3'h4: ms = `SBCW_P4_MS;
      3'h5: ms = `SBCW_P5_MS;
      3'h6: ms = `SBCW_P6_MS;
      3'h7: ms = `SBCW_P7_MS;
    endcase
    period_ms_of = ms;
  endfunction

  // ----------------------------------------
  // Serial access
  // ----------------------------------------
  sbcw_spi_slave u_spi (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe),
    .head_byte(head_status),
    .rdata(rdata),
    .addr(spi_addr),
    .wdata(spi_wdata),
    .wr(spi_wr),
    .done(spi_done),
    .bad_len(spi_bad_len)
  );

  // Unmapped addresses read zero and drop writes
  always_comb begin
    rdata = `SBCW_ZERO8;
    if (hit(spi_addr, `SBCW_ADDR_WDOG)) begin
      rdata = wdog_q;
    end else if (hit(spi_addr, `SBCW_ADDR_BUS)) begin
      rdata = bus_q;
    end else if (hit(spi_addr, `SBCW_ADDR_IWAKE)) begin
      rdata = iwake_q;
    end else if (hit(spi_addr, `SBCW_ADDR_EWAKE)) begin
      rdata = ewake_q;
    end
  end

  assign parity_ok = ~(^spi_wdata);
  assign wr_wdog = spi_wr & hit(spi_addr, `SBCW_ADDR_WDOG) & parity_ok;
  assign wr_bus = spi_wr & hit(spi_addr, `SBCW_ADDR_BUS);
  assign wr_iwake = spi_wr & hit(spi_addr, `SBCW_ADDR_IWAKE);
  assign wr_ewake = spi_wr & hit(spi_addr, `SBCW_ADDR_EWAKE);

  // First enabled cycle after reset reloads values that depend on straps
  assign any_soft = soft_reset | st.boot;
  assign ew_force = failsafe_entry & ~ewake_q[`SBCW_EW_VSENSE];

  // ----------------------------------------
  // Field slices
  // ----------------------------------------
  assign period_code = wdog_q[`SBCW_WD_PERIOD_HI:`SBCW_WD_PERIOD_LO];
  assign mode_code = bus_q[`SBCW_BUS_MODE_HI:`SBCW_BUS_MODE_LO];
  assign head_status = {7'h00, st.spi_fail};

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  sbcw_cfg_reg #(
    .POR(`SBCW_WDOG_POR),
    .WMASK(`SBCW_WDOG_WMASK),
    .KEEP(`SBCW_WDOG_KEEP)
  ) u_wdog (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .soft_rst(any_soft),
    .soft_val(`SBCW_WDOG_POR),
    .wr(wr_wdog),
    .wdata(spi_wdata),
    .restart(restart_entry),
    .restart_val(`SBCW_WDOG_RESTART),
    .force_en(1'b0),
    .force_mask(`SBCW_ZERO8),
    .force_val(`SBCW_ZERO8),
    .q(wdog_q)
  );

  sbcw_cfg_reg #(
    .POR(`SBCW_BUS_POR),
    .WMASK(`SBCW_BUS_WMASK),
    .KEEP(`SBCW_BUS_KEEP)
  ) u_bus (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .soft_rst(any_soft),
    .soft_val(dev_mode ? `SBCW_BUS_POR_DEV : `SBCW_BUS_POR),
    .wr(wr_bus),
    .wdata(spi_wdata),
    .restart(restart_entry),
    .restart_val({6'h00, restart_can_mode}),
    .force_en(failsafe_entry),
    .force_mask(`SBCW_ALL8),
    .force_val(`SBCW_BUS_FAILSAFE),
    .q(bus_q)
  );

  sbcw_cfg_reg #(
    .POR(`SBCW_IWAKE_POR),
    .WMASK(`SBCW_IWAKE_WMASK),
    .KEEP(`SBCW_IWAKE_KEEP)
  ) u_iwake (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .soft_rst(any_soft),
    .soft_val(`SBCW_IWAKE_POR),
    .wr(wr_iwake),
    .wdata(spi_wdata),
    .restart(restart_entry),
    .restart_val(`SBCW_ZERO8),
    .force_en(stop_to_normal),
    .force_mask(`SBCW_IWAKE_CLR_STOP),
    .force_val(`SBCW_ZERO8),
    .q(iwake_q)
  );

  sbcw_cfg_reg #(
    .POR(`SBCW_EWAKE_POR),
    .WMASK(`SBCW_EWAKE_WMASK),
    .KEEP(`SBCW_EWAKE_KEEP)
  ) u_ewake (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .soft_rst(any_soft),
    .soft_val(`SBCW_EWAKE_POR),
    .wr(wr_ewake),
    .wdata(spi_wdata),
    .restart(restart_entry),
    .restart_val(`SBCW_ZERO8),
    .force_en(ew_force),
    .force_mask(`SBCW_EWAKE_FS_MASK),
    .force_val(`SBCW_EWAKE_FS_VAL),
    .q(ewake_q)
  );

  // ----------------------------------------
  // Derived controls
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.boot = 1'b0;
    next_st.wdog_off_stop = wdog_q[`SBCW_WD_OFF_A] & iwake_q[`SBCW_IW_OFF_B];
    next_st.long_start = bus_wake_in_stop & wdog_q[`SBCW_WD_BUS_START];
    next_st.period_ms = period_ms_of(period_code);
    next_st.fail_pulse = spi_wr & hit(spi_addr, `SBCW_ADDR_WDOG) & ~parity_ok;
    // Set wins over clear so a failure in a clean frame's cycle is kept
    if (spi_done) begin
      next_st.spi_fail = 1'b0;
    end
    if (next_st.fail_pulse | spi_bad_len) begin
      next_st.spi_fail = 1'b1;
    end
    next_st.irq_n = ~(wake_pending | (ewake_q[`SBCW_EW_GLOBAL] & status_pending));
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{
        boot: 1'b1,
        spi_fail: 1'b0,
        wdog_off_stop: 1'b0,
        long_start: 1'b0,
        fail_pulse: 1'b0,
        irq_n: 1'b1,
        period_ms: `SBCW_P4_MS
      };
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wdog_window = wdog_q[`SBCW_WD_WINDOW];
  assign period_select = period_code;
  assign wdog_period_ms = st.period_ms;
  assign wdog_halted = in_stop & st.wdog_off_stop;
  assign wdog_long_window_start = st.long_start;
  assign can_mode = mode_code;
  assign cyclic_wake_enable = iwake_q[`SBCW_IW_CYCLIC];
  // Voltage sensing takes the pin away from wake detection
  assign pin_wake_enable = ewake_q[`SBCW_EW_PIN] & ~ewake_q[`SBCW_EW_VSENSE];
  assign voltage_sense_select = ewake_q[`SBCW_EW_VSENSE];
  assign cfg_write_fail = st.fail_pulse;
  assign irq_out_n = st.irq_n;
endmodule

// [testbench/sbcw_cfg_checker.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Port-level checker for the config block
// ----------------------------------------
module sbcw_cfg_checker (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic miso_oe,
  input wire logic soft_reset,
  input wire logic restart_entry,
  input wire logic [1:0] restart_can_mode,
  input wire logic failsafe_entry,
  input wire logic dev_mode,
  input wire logic in_stop,
  input wire logic bus_wake_in_stop,
  input wire logic wake_pending,
  input wire logic status_pending,
  input wire logic [2:0] period_select,
  input wire logic [13:0] wdog_period_ms,
  input wire logic wdog_halted,
  input wire logic wdog_long_window_start,
  input wire logic [1:0] can_mode,
  input wire logic pin_wake_enable,
  input wire logic voltage_sense_select,
  input wire logic cfg_write_fail,
  input wire logic irq_out_n
);
  localparam logic [13:0] MS [8] = '{14'h000a, 14'h0014, 14'h0032, 14'h0064, 14'h00c8, 14'h01f4, 14'h03e8,
    14'h2710};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Decode is a flop, so only judged once the code has settled
  property p_period; $stable(period_select) |-> wdog_period_ms == MS[period_select]; endproperty
  a_period: assert property (p_period) else $error("period decode wrong");
  property p_halt; wdog_halted |-> in_stop; endproperty
  a_halt: assert property (p_halt) else $error("halted outside stop");
  property p_lws; wdog_long_window_start |-> $past(bus_wake_in_stop); endproperty
  a_lws: assert property (p_lws) else $error("long window without bus wake");
  property p_irq_lo; $past(wake_pending) |-> !irq_out_n; endproperty
  a_irq_lo: assert property (p_irq_lo) else $error("wake did not raise irq");
  property p_irq_hi; !$past(wake_pending) && !$past(status_pending) |-> irq_out_n; endproperty
  a_irq_hi: assert property (p_irq_hi) else $error("irq without source");
  property p_vsense; voltage_sense_select |-> !pin_wake_enable; endproperty
  a_vsense: assert property (p_vsense) else $error("pin wake while sensing");
  property p_fs_bus; failsafe_entry && !soft_reset |=> can_mode == 2'h1; endproperty
  a_fs_bus: assert property (p_fs_bus) else $error("failsafe bus mode wrong");
  property p_fs_ew; failsafe_entry && !soft_reset && !voltage_sense_select |=> pin_wake_enable; endproperty
  a_fs_ew: assert property (p_fs_ew) else $error("failsafe pin wake off");
  property p_rst; restart_entry && !soft_reset && !failsafe_entry |=> can_mode == $past(restart_can_mode); endproperty
  a_rst: assert property (p_rst) else $error("restart bus mode wrong");
  property p_soft; soft_reset |=> can_mode == ($past(dev_mode) ? 2'h3 : 2'h0) && period_select == 3'h4; endproperty
  a_soft: assert property (p_soft) else $error("soft reset values wrong");
  property p_wfail; cfg_write_fail |-> $past(cs_n) && $past(cs_n, 2); endproperty
  a_wfail: assert property (p_wfail) else $error("write fail inside frame");
  property p_oe; miso_oe == !cs_n; endproperty
  a_oe: assert property (p_oe) else $error("data output enable wrong");
endmodule

bind sbcw_cfg_top sbcw_cfg_checker u_chk (.mclk(mclk), .arst_n(arst_n), .cs_n(cs_n), .soft_reset(soft_reset),
  .restart_entry(restart_entry), .restart_can_mode(restart_can_mode), .failsafe_entry(failsafe_entry),
  .dev_mode(dev_mode), .in_stop(in_stop), .bus_wake_in_stop(bus_wake_in_stop), .wake_pending(wake_pending),
  .status_pending(status_pending), .period_select(period_select), .wdog_period_ms(wdog_period_ms),
  .wdog_halted(wdog_halted), .wdog_long_window_start(wdog_long_window_start), .can_mode(can_mode),
  .pin_wake_enable(pin_wake_enable), .voltage_sense_select(voltage_sense_select),
  .cfg_write_fail(cfg_write_fail), .irq_out_n(irq_out_n), .miso_oe(miso_oe));

// [testbench/sbcw_host_model.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Host side serial master
// ----------------------------------------
module sbcw_host_model (
  input wire logic mclk,
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Phases of 4+ mclk, above the 1-cycle minimum of the sampler
  task automatic xfer(input logic [15:0] f, output logic [15:0] r);
    @(negedge mclk) cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      repeat (2) @(negedge mclk);
      mosi = f[i];
      repeat (3) @(negedge mclk);
      sclk = 1'b1;
      r[i] = miso;
      repeat (4) @(negedge mclk);
      sclk = 1'b0;
    end
    repeat (3) @(negedge mclk);
    cs_n = 1'b1;
    // Deselected data line shows no stale bit
    mosi = ~mosi;
    repeat (4) @(negedge mclk);
  endtask

  // Cut frame: deselect after nb clock pulses
  task automatic cut(input int nb);
    @(negedge mclk) cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      repeat (5) @(negedge mclk);
      sclk = 1'b1;
      repeat (4) @(negedge mclk);
      sclk = 1'b0;
    end
    repeat (3) @(negedge mclk);
    cs_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Bench top
// ----------------------------------------
module tb_top;
  logic mclk = 1'b0, arst_n = 1'b0, soft_reset = 1'b0, restart_entry = 1'b0, failsafe_entry = 1'b0;
  logic dev_mode = 1'b0, stop_to_normal = 1'b0, in_stop = 1'b0, bus_wake_in_stop = 1'b0, ce = 1'b1;
  logic wake_pending = 1'b0, status_pending = 1'b0;
  logic [1:0] restart_can_mode = 2'h0;
  logic sclk, cs_n, mosi, miso, miso_oe, wdog_window, wdog_halted, wdog_long_window_start;
  logic cyclic_wake_enable, pin_wake_enable, voltage_sense_select, cfg_write_fail, irq_out_n;
  logic [2:0] period_select;
  logic [13:0] wdog_period_ms;
  logic [1:0] can_mode;
  logic [13:0] ms_tab [8] = '{14'h000a, 14'h0014, 14'h0032, 14'h0064, 14'h00c8, 14'h01f4, 14'h03e8, 14'h2710};
  int fail_count = 0, num_checks = 0, n_fail = 0, n_lws = 0;

  always #2 mclk = ~mclk;
  // Pulses last one cycle, so they are counted rather than sampled
  always @(posedge mclk) begin
    n_fail <= n_fail + ((cfg_write_fail === 1'b1) ? 1 : 0);
    n_lws <= n_lws + ((wdog_long_window_start === 1'b1) ? 1 : 0);
  end

  sbcw_host_model host (.mclk(mclk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  // Clock enable is dropped once to prove the freeze
  sbcw_cfg_top dut (.mclk(mclk), .arst_n(arst_n), .ce(ce), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .soft_reset(soft_reset), .restart_entry(restart_entry),
    .restart_can_mode(restart_can_mode), .failsafe_entry(failsafe_entry), .dev_mode(dev_mode),
    .stop_to_normal(stop_to_normal), .in_stop(in_stop), .bus_wake_in_stop(bus_wake_in_stop),
    .wake_pending(wake_pending), .status_pending(status_pending), .wdog_window(wdog_window),
    .period_select(period_select), .wdog_period_ms(wdog_period_ms), .wdog_halted(wdog_halted),
    .wdog_long_window_start(wdog_long_window_start), .can_mode(can_mode),
    .cyclic_wake_enable(cyclic_wake_enable), .pin_wake_enable(pin_wake_enable),
    .voltage_sense_select(voltage_sense_select), .cfg_write_fail(cfg_write_fail), .irq_out_n(irq_out_n));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    if (a == 7'h03) d[7] = ^d[6:0];
    host.xfer({d, a, 1'b1}, r);
    tick(2);
  endtask

  task automatic rd(input string nm, input logic [6:0] a, input logic [7:0] e);
    logic [15:0] r;
    host.xfer({8'h00, a, 1'b0}, r);
    chk(nm, {8'h00, e}, {8'h00, r[15:8]});
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    logic [15:0] r;
    int n;
    tick(4);
    arst_n = 1'b1;
    tick(3);
    rd("wdog_por", 7'h03, 8'h14);
    rd("bus_por", 7'h04, 8'h00);
    rd("iwake_por", 7'h06, 8'h00);
    rd("ewake_por", 7'h07, 8'h01);
    rd("unmapped", 7'h05, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(7'h03, 8'(k));
      chk("period_ms", 16'(ms_tab[k]), 16'(wdog_period_ms));
      chk("window_off", 16'h0, 16'(wdog_window));
    end
    wr(7'h03, 8'h27);
    chk("window_on", 16'h1, 16'(wdog_window));
    wr(7'h04, 8'hff);
    rd("bus_rsv", 7'h04, 8'h03);
    wr(7'h06, 8'hff);
    rd("iwake_rsv", 7'h06, 8'h44);
    chk("cyclic", 16'h1, 16'(cyclic_wake_enable));
    wr(7'h07, 8'hff);
    rd("ewake_rsv", 7'h07, 8'ha1);
    chk("pin_wake_vs", 16'h0, 16'(pin_wake_enable));
    wr(7'h07, 8'h01);
    chk("pin_wake", 16'h1, 16'(pin_wake_enable));
    for (int m = 0; m < 4; m++) begin
      wr(7'h04, 8'(m));
      chk("can_mode", 16'(m), 16'(can_mode));
    end
    n = n_fail;
    host.xfer({8'h85, 7'h03, 1'b1}, r);
    chk("write_fail", 16'(n + 1), 16'(n_fail));
    host.xfer({8'h00, 7'h03, 1'b0}, r);
    chk("fail_flag", 16'h1, 16'(r[0]));
    chk("wdog_kept", 16'h27, 16'(r[15:8]));
    host.cut(8);
    host.xfer({8'h00, 7'h04, 1'b0}, r);
    chk("len_flag", 16'h1, 16'(r[0]));
    in_stop = 1'b1;
    wr(7'h03, 8'h40);
    wr(7'h06, 8'h04);
    chk("halted", 16'h1, 16'(wdog_halted));
    stop_to_normal = 1'b1;
    tick(1);
    stop_to_normal = 1'b0;
    tick(2);
    chk("halt_clr", 16'h0, 16'(wdog_halted));
    rd("iwake_clr", 7'h06, 8'h00);
    wr(7'h06, 8'h04);
    wr(7'h03, 8'h00);
    chk("halt_b_only", 16'h0, 16'(wdog_halted));
    ce = 1'b0;
    stop_to_normal = 1'b1;
    tick(1);
    stop_to_normal = 1'b0;
    tick(1);
    ce = 1'b1;
    rd("ce_freeze", 7'h06, 8'h04);
    in_stop = 1'b0;
    for (int b = 0; b < 2; b++) begin
      wr(7'h03, b ? 8'h10 : 8'h00);
      n = n_lws;
      bus_wake_in_stop = 1'b1;
      tick(1);
      bus_wake_in_stop = 1'b0;
      tick(2);
      chk("long_window", 16'(n + b), 16'(n_lws));
    end
    wr(7'h03, 8'h73);
    wr(7'h04, 8'h03);
    wr(7'h06, 8'h44);
    wr(7'h07, 8'ha1);
    restart_can_mode = 2'h2;
    restart_entry = 1'b1;
    tick(1);
    restart_entry = 1'b0;
    tick(2);
    rd("wdog_rst", 7'h03, 8'hb4);
    rd("bus_rst", 7'h04, 8'h02);
    rd("iwake_rst", 7'h06, 8'h40);
    rd("ewake_rst", 7'h07, 8'ha1);
    status_pending = 1'b1;
    tick(2);
    chk("irq_global", 16'h0, 16'(irq_out_n));
    wr(7'h07, 8'h01);
    chk("irq_masked", 16'h1, 16'(irq_out_n));
    status_pending = 1'b0;
    wake_pending = 1'b1;
    tick(2);
    chk("irq_wake", 16'h0, 16'(irq_out_n));
    wake_pending = 1'b0;
    wr(7'h07, 8'h80);
    wr(7'h04, 8'h03);
    failsafe_entry = 1'b1;
    tick(1);
    failsafe_entry = 1'b0;
    tick(2);
    rd("bus_fs", 7'h04, 8'h01);
    rd("ewake_fs", 7'h07, 8'h81);
    dev_mode = 1'b1;
    soft_reset = 1'b1;
    tick(1);
    soft_reset = 1'b0;
    tick(2);
    rd("wdog_soft", 7'h03, 8'h14);
    rd("bus_dev", 7'h04, 8'h03);
    rd("ewake_soft", 7'h07, 8'h01);
    report_and_stop;
  end

  initial begin
    repeat (40000) @(posedge mclk);
    fail_count++;
    report_and_stop;
  end
endmodule
